/* File: logic/ssr_top.sv */
// Purpose: synchronous serial port, spi shifter and i2c repeated start
// Assumes: pins are asynchronous to clk; tmr2_match is a clk pulse
// Notes: input pins pass a three-stage filter, so sampled data lags
`timescale 1ns/100ps
module ssr_top (
    input logic clk,
    input logic reset_n,
    input logic [7:0] serial_port_control_one,
    input logic [7:0] serial_port_status_reg,
    input logic [7:0] addr_or_baud_reload_reg,
    input logic buf_wr_en,
    input logic [7:0] buf_wr_data,
    input logic tmr2_match,
    output logic [7:0] serial_transfer_buffer,
    output logic spi_done,
    output logic spi_busy,
    input logic sdi_in,
    output logic sdo_out,
    output logic sdo_oe,
    input logic sck_in,
    output logic sck_out,
    output logic sck_oe,
    input logic ss_n_in,
    input logic rstart_req,
    output logic rstart_busy,
    output logic rstart_done,
    output logic bus_coll,
    input logic bus_coll_clr,
    input logic scl_in,
    output logic scl_out,
    output logic scl_oe,
    input logic sda_in,
    output logic sda_out,
    output logic sda_oe
);
    ////////////////////////////////////////////////////////////////////////////
    typedef struct packed {
        logic [4:0] sync1;
        logic [4:0] sync2;
        logic [4:0] sync3;
        logic [4:0] filt;
        ssr_pkg::ssr_spi_state_type spi_st;
        logic [5:0] div_cnt;
        logic [4:0] half_cnt;
        logic [3:0] cap_cnt;
        logic [7:0] shift;
        logic [7:0] rx_buf;
        logic sdo;
        logic sck;
        logic done;
        ssr_pkg::ssr_rs_state_type rs_st;
        logic brg_load;
        logic scl_low;
        logic sda_low;
        logic coll;
        logic rs_done;
    } ssr_top_state_type;

    localparam ssr_top_state_type ST_RESET = '{
        sync1: ssr_pkg::SYNC_RST,
        sync2: ssr_pkg::SYNC_RST,
        sync3: ssr_pkg::SYNC_RST,
        filt: ssr_pkg::SYNC_RST,
        spi_st: ssr_pkg::SPI_IDLE,
        rs_st: ssr_pkg::RS_IDLE,
        default: '0
    };

    function automatic logic [5:0] half_limit(input logic [3:0] mode);
        case (mode)
            ssr_pkg::MODE_DIV4: half_limit = ssr_pkg::HALF_DIV4;
            ssr_pkg::MODE_DIV16: half_limit = ssr_pkg::HALF_DIV16;
            default: half_limit = ssr_pkg::HALF_DIV64;
        endcase
    endfunction : half_limit

    // h counts serial clock edges; even ones leave the idle level
    function automatic logic is_cap(input logic cke, input logic input_sample_phase, input logic [4:0] h);
        if (cke) begin
            is_cap = input_sample_phase ? h[0] : !h[0];
        end else begin
            is_cap = input_sample_phase ? (!h[0] && h != 5'h00) : h[0];
        end
    endfunction : is_cap

    function automatic logic is_shift(input logic cke, input logic [4:0] h);
        if (cke) begin
            is_shift = h[0] && h < (ssr_pkg::EDGES_PER_BYTE - 5'h01);
        end else begin
            is_shift = !h[0] && h < ssr_pkg::EDGES_PER_BYTE;
        end
    endfunction : is_shift

    ////////////////////////////////////////////////////////////////////////////
    logic [1:0] rst_sync_q;
    logic rst_n;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rst_sync_q <= ssr_pkg::RST_SYNC_RST;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end

    assign rst_n = rst_sync_q[1];

    ////////////////////////////////////////////////////////////////////////////
    ssr_top_state_type s_q;
    ssr_top_state_type s_d;
    ssr_brg_if brg ();

    ssr_brg u_brg (
        .clk(clk),
        .rst_n(rst_n),
        .bus(brg.cnt)
    );

    logic [3:0] mode;
    logic en, ckp, cke, input_sample_phase;
    logic is_master, is_slave, is_i2c, ss_used, slave_act;
    logic [4:0] agree, filt_n;
    logic sck_edge, scl_fall, div_hit, tick, cap, shf, spi_idle;
    logic coll_ev;

    // options
    assign mode = serial_port_control_one[3:0];
    assign en = serial_port_control_one[ssr_pkg::CTL_EN_BIT];
    assign ckp = serial_port_control_one[ssr_pkg::CTL_CKP_BIT];
    assign cke = serial_port_status_reg[ssr_pkg::STS_CKE_BIT];
    assign is_master = en && mode <= ssr_pkg::MODE_TMR2;
    assign is_slave = en && (mode == ssr_pkg::MODE_SLAVE_SS || mode == ssr_pkg::MODE_SLAVE_NOSS);
    assign is_i2c = en && mode == ssr_pkg::MODE_I2C_MASTER;
    assign ss_used = mode == ssr_pkg::MODE_SLAVE_SS;
    // a slave can only sample mid-bit; end sampling needs a clock it does not own
    assign input_sample_phase = is_master && serial_port_status_reg[ssr_pkg::STS_SMP_BIT];

    // a pin level counts once the second and third stages agree
    assign agree = ~(s_q.sync2 ^ s_q.sync3);
    assign filt_n = (agree & s_q.sync3) | (~agree & s_q.filt);
    assign sck_edge = filt_n[ssr_pkg::PIN_SCK] ^ s_q.filt[ssr_pkg::PIN_SCK];
    assign scl_fall = !filt_n[ssr_pkg::PIN_SCL] && s_q.filt[ssr_pkg::PIN_SCL];

    assign slave_act = is_slave && (!ss_used || !filt_n[ssr_pkg::PIN_SS]);
    assign div_hit = s_q.div_cnt == half_limit(mode) - 6'h01;
    always_comb begin
        tick = 1'b0;
        if (is_master) begin
            if (s_q.spi_st == ssr_pkg::SPI_RUN) begin
                // timer output toggles the clock: half its rate
                tick = (mode == ssr_pkg::MODE_TMR2) ? tmr2_match : div_hit;
            end
        end else begin
            tick = slave_act && sck_edge;
        end
    end
    assign cap = tick && is_cap(cke, input_sample_phase, s_q.half_cnt);
    assign shf = tick && is_shift(cke, s_q.half_cnt);
    assign spi_idle = is_master ? s_q.spi_st == ssr_pkg::SPI_IDLE : s_q.half_cnt == 5'h00;

    ////////////////////////////////////////////////////////////////////////////
    always_comb begin
        s_d = s_q;
        coll_ev = 1'b0;
        s_d.done = 1'b0;
        s_d.rs_done = 1'b0;
        s_d.brg_load = 1'b0;
        s_d.sync1 = {sda_in, scl_in, ss_n_in, sck_in, sdi_in};
        s_d.sync2 = s_q.sync1;
        s_d.sync3 = s_q.sync2;
        s_d.filt = filt_n;

        // spi shifter
        if (!is_master || s_q.spi_st == ssr_pkg::SPI_IDLE) begin
            s_d.sck = ckp;
            s_d.div_cnt = 6'h00;
        end else begin
            s_d.div_cnt = div_hit ? 6'h00 : s_q.div_cnt + 6'h01;
        end
        if (tick) begin
            if (s_q.half_cnt < ssr_pkg::EDGES_PER_BYTE) begin
                s_d.sck = ~s_q.sck;
            end
            if (shf) begin
                s_d.sdo = cap ? s_q.shift[6] : s_q.shift[7];
            end
            if (cap) begin
                s_d.shift = {s_q.shift[6:0], filt_n[ssr_pkg::PIN_SDI]};
                s_d.cap_cnt = s_q.cap_cnt + 4'h1;
            end
            s_d.half_cnt = s_q.half_cnt + 5'h01;
            // end on the later of the last clock edge and the last capture, so sck gets back to idle
            if (s_q.half_cnt == ((!cke && input_sample_phase) ? ssr_pkg::EDGES_PER_BYTE
                    : ssr_pkg::EDGES_PER_BYTE - 5'h01)) begin
                s_d.rx_buf = s_d.shift;
                s_d.done = 1'b1;
                s_d.half_cnt = 5'h00;
                s_d.cap_cnt = 4'h0;
                s_d.spi_st = ssr_pkg::SPI_IDLE;
                s_d.sck = ckp;
            end
        end else if (buf_wr_en && spi_idle && (is_master || is_slave)) begin
            // a write during a transfer is dropped: the shifter is busy
            s_d.shift = buf_wr_data;
            s_d.sdo = buf_wr_data[7];
            if (is_master) begin
                s_d.spi_st = ssr_pkg::SPI_RUN;
                s_d.half_cnt = 5'h00;
                s_d.cap_cnt = 4'h0;
            end
        end
        if (!is_master) begin
            s_d.spi_st = ssr_pkg::SPI_IDLE;
        end
        // deselect or disable throws away a partial byte
        if ((!is_master && !is_slave) || (is_slave && ss_used && filt_n[ssr_pkg::PIN_SS])) begin
            s_d.half_cnt = 5'h00;
            s_d.cap_cnt = 4'h0;
        end

        // i2c repeated start sequencer
        if (bus_coll_clr) begin
            s_d.coll = 1'b0;
        end
        case (s_q.rs_st)
            ssr_pkg::RS_IDLE: begin
                if (rstart_req && is_i2c) begin
                    s_d.sda_low = 1'b0;
                    s_d.scl_low = 1'b1;
                    s_d.brg_load = 1'b1;
                    s_d.rs_st = ssr_pkg::RS_DELAY;
                end
            end
            ssr_pkg::RS_DELAY: begin
                if (brg.expired) begin
                    s_d.scl_low = 1'b0;
                    s_d.rs_st = ssr_pkg::RS_SCL_REL;
                end
            end
            ssr_pkg::RS_SCL_REL: begin
                if (filt_n[ssr_pkg::PIN_SCL]) begin
                    if (!filt_n[ssr_pkg::PIN_SDA]) begin
                        coll_ev = 1'b1;
                    end else begin
                        s_d.brg_load = 1'b1;
                        s_d.rs_st = ssr_pkg::RS_SETUP;
                    end
                end
            end
            ssr_pkg::RS_SETUP: begin
                // a falling data line here is tolerated
                if (scl_fall && !s_q.sda_low) begin
                    coll_ev = 1'b1;
                end else if (brg.expired) begin
                    if (filt_n[ssr_pkg::PIN_SCL] && filt_n[ssr_pkg::PIN_SDA]) begin
                        s_d.sda_low = 1'b1;
                        s_d.brg_load = 1'b1;
                        s_d.rs_st = ssr_pkg::RS_HOLD;
                    end else begin
                        coll_ev = 1'b1;
                    end
                end
            end
            ssr_pkg::RS_HOLD: begin
                if (brg.expired) begin
                    s_d.scl_low = 1'b1;
                    s_d.rs_done = 1'b1;
                    s_d.rs_st = ssr_pkg::RS_IDLE;
                end
            end
            default: begin
                s_d.rs_st = ssr_pkg::RS_IDLE;
            end
        endcase
        if (coll_ev) begin
            s_d.coll = 1'b1;
            s_d.scl_low = 1'b0;
            s_d.sda_low = 1'b0;
            s_d.brg_load = 1'b0;
            s_d.rs_st = ssr_pkg::RS_IDLE;
        end
        if (!is_i2c) begin
            s_d.scl_low = 1'b0;
            s_d.sda_low = 1'b0;
            s_d.rs_st = ssr_pkg::RS_IDLE;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_q <= ST_RESET;
        end else begin
            s_q <= s_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    assign brg.load = s_q.brg_load;
    assign brg.stop = coll_ev || !is_i2c;
    assign brg.reload = addr_or_baud_reload_reg[ssr_pkg::BAUD_MSB:0];

    assign serial_transfer_buffer = s_q.rx_buf;
    assign spi_done = s_q.done;
    assign spi_busy = is_master ? s_q.spi_st == ssr_pkg::SPI_RUN : s_q.half_cnt != 5'h00;
    assign sdo_out = s_q.sdo;
    assign sdo_oe = is_master || slave_act;
    assign sck_out = s_q.sck;
    assign sck_oe = is_master;
    // open-drain lines: only ever pulled low
    assign scl_out = 1'b0;
    assign sda_out = 1'b0;
    assign scl_oe = s_q.scl_low;
    assign sda_oe = s_q.sda_low;
    assign rstart_busy = s_q.rs_st != ssr_pkg::RS_IDLE;
    assign rstart_done = s_q.rs_done;
    assign bus_coll = s_q.coll;

    ////////////////////////////////////////////////////////////////////////////
    a_sck_idle_level: assert property (@(posedge clk) disable iff (!rst_n)
        is_master && $past(is_master) && $past(ckp) == ckp
        && s_q.spi_st == ssr_pkg::SPI_IDLE && $past(s_q.spi_st) == ssr_pkg::SPI_IDLE
        |-> sck_out == ckp)
        else $error("serial clock not at idle level");

    a_slave_no_drive: assert property (@(posedge clk) disable iff (!rst_n)
        is_slave |-> !sck_oe && s_q.spi_st == ssr_pkg::SPI_IDLE)
        else $error("slave drove the serial clock");

    a_ss_quiet_out: assert property (@(posedge clk) disable iff (!rst_n)
        is_slave && ss_used && filt_n[ssr_pkg::PIN_SS] |-> !sdo_oe && s_d.half_cnt == 5'h00)
        else $error("deselected slave still active");

    a_byte_div4: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(spi_busy) && is_master && mode == ssr_pkg::MODE_DIV4 && $stable(mode)
        |-> ##[32:34] spi_done)
        else $error("fosc/4 byte did not finish in time");

    a_byte_capture_count: assert property (@(posedge clk) disable iff (!rst_n)
        s_d.done |-> s_q.cap_cnt == (cap ? ssr_pkg::LAST_BIT : ssr_pkg::LAST_BIT + 4'h1))
        else $error("byte ended without eight captures");

    a_rise_low_data: assert property (@(posedge clk) disable iff (!rst_n)
        s_q.rs_st == ssr_pkg::RS_SCL_REL && is_i2c && filt_n[ssr_pkg::PIN_SCL]
        && !filt_n[ssr_pkg::PIN_SDA] |=> bus_coll && !scl_oe && !sda_oe)
        else $error("low data at clock rise not flagged");

    a_setup_scl_fall: assert property (@(posedge clk) disable iff (!rst_n)
        s_q.rs_st == ssr_pkg::RS_SETUP && is_i2c && scl_fall
        |=> bus_coll && s_q.rs_st == ssr_pkg::RS_IDLE)
        else $error("early clock fall not flagged");

    a_data_fall_ok: assert property (@(posedge clk) disable iff (!rst_n)
        s_q.rs_st == ssr_pkg::RS_SETUP && is_i2c && !scl_fall && !brg.expired
        && !bus_coll && !bus_coll_clr |=> !bus_coll)
        else $error("data fall during setup flagged as collision");

    a_drive_data_low: assert property (@(posedge clk) disable iff (!rst_n)
        s_q.rs_st == ssr_pkg::RS_SETUP && is_i2c && !scl_fall && brg.expired
        && filt_n[ssr_pkg::PIN_SCL] && filt_n[ssr_pkg::PIN_SDA]
        |=> sda_oe && s_q.rs_st == ssr_pkg::RS_HOLD && brg.load)
        else $error("data not driven low after setup");

    a_hold_end_clock: assert property (@(posedge clk) disable iff (!rst_n)
        s_q.rs_st == ssr_pkg::RS_HOLD && is_i2c && brg.expired
        |=> scl_oe && sda_oe && rstart_done && !rstart_busy)
        else $error("restart did not end with clock low");

    a_coll_sticky: assert property (@(posedge clk) disable iff (!rst_n)
        bus_coll && !bus_coll_clr |=> bus_coll)
        else $error("collision flag lost");

    c_master_byte: cover property (@(posedge clk) disable iff (!rst_n)
        is_master && spi_done);
    c_slave_byte: cover property (@(posedge clk) disable iff (!rst_n)
        is_slave && spi_done);
    c_restart_done: cover property (@(posedge clk) disable iff (!rst_n)
        rstart_done);
    c_collision: cover property (@(posedge clk) disable iff (!rst_n)
        $rose(bus_coll));
endmodule : ssr_top

/* File: pkg/ssr_pkg.sv */
// Purpose: shared constants and types for the synchronous serial port
// Assumes: control and status bits arrive as plain ports, no bus
// Notes: mode codes follow the low nibble of the first control register
package ssr_pkg;
    localparam logic [3:0] MODE_DIV4 = 4'h0;
    localparam logic [3:0] MODE_DIV16 = 4'h1;
    localparam logic [3:0] MODE_DIV64 = 4'h2;
    localparam logic [3:0] MODE_TMR2 = 4'h3;
    localparam logic [3:0] MODE_SLAVE_SS = 4'h4;
    localparam logic [3:0] MODE_SLAVE_NOSS = 4'h5;
    localparam logic [3:0] MODE_I2C_MASTER = 4'h8;
    localparam int CTL_CKP_BIT = 4;
    localparam int CTL_EN_BIT = 5;
    localparam int STS_CKE_BIT = 6;
    localparam int STS_SMP_BIT = 7;
    localparam int BAUD_MSB = 6;
    // half periods of the serial clock in oscillator cycles
    localparam logic [5:0] HALF_DIV4 = 6'h02;
    localparam logic [5:0] HALF_DIV16 = 6'h08;
    localparam logic [5:0] HALF_DIV64 = 6'h20;
    localparam logic [4:0] EDGES_PER_BYTE = 5'h10;
    localparam logic [3:0] LAST_BIT = 4'h7;
    localparam int PIN_SDI = 0;
    localparam int PIN_SCK = 1;
    localparam int PIN_SS = 2;
    localparam int PIN_SCL = 3;
    localparam int PIN_SDA = 4;
    localparam int PIN_COUNT = 5;
    // pins idle high: pulled-up bus lines, select inactive
    localparam logic [4:0] SYNC_RST = 5'h1F;
    localparam logic [1:0] RST_SYNC_RST = 2'h0;
    typedef enum logic {SPI_IDLE, SPI_RUN} ssr_spi_state_type;
    typedef enum logic [2:0] {RS_IDLE, RS_DELAY, RS_SCL_REL, RS_SETUP, RS_HOLD} ssr_rs_state_type;
endpackage : ssr_pkg

/* File: pkg/ssr_brg_if.sv */
// Purpose: link between the sequencer and the baud reload counter
// Assumes: both ends on the same clock
// Notes: load is a one-cycle pulse; stop is held for as long as i2c mode is off
`timescale 1ns/100ps
interface ssr_brg_if;
    logic load;
    logic stop;
    logic [6:0] reload;
    logic expired;
    modport ctrl (output load, output stop, output reload, input expired);
    modport cnt (input load, input stop, input reload, output expired);
endinterface : ssr_brg_if

/* File: logic/ssr_brg.sv */
// Purpose: baud reload counter for bus timing
// Assumes: reload value stable while counting
// Notes: expired pulses reload+2 cycles after load is seen
`timescale 1ns/100ps
module ssr_brg (
    input logic clk,
    input logic rst_n,
    ssr_brg_if.cnt bus
);
    typedef struct packed {
        logic run;
        logic [6:0] cnt;
        logic exp;
    } ssr_brg_state_type;

    ssr_brg_state_type s_q;
    ssr_brg_state_type s_d;

    always_comb begin
        s_d = s_q;
        s_d.exp = 1'b0;
        if (bus.stop) begin
            s_d.run = 1'b0;
        end else if (bus.load) begin
            s_d.cnt = bus.reload;
            s_d.run = 1'b1;
        end else if (s_q.run) begin
            if (s_q.cnt == 7'h00) begin
                s_d.exp = 1'b1;
                s_d.run = 1'b0;
            end else begin
                s_d.cnt = s_q.cnt - 7'h01;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign bus.expired = s_q.exp;

    a_brg_reload: assert property (@(posedge clk) disable iff (!rst_n)
        bus.load && !bus.stop |=> s_q.run && s_q.cnt == $past(bus.reload))
        else $error("baud counter did not take the reload value");
endmodule : ssr_brg

/* File: sim/ssr_peer.sv */
// Purpose: far-side model: spi peer and pulled-up i2c lines with faults
// Assumes: acts as spi slave while the device drives sck, else master
// Notes: fault 1 holds data low, fault 2 grabs the clock after release
`timescale 1ns/100ps
module ssr_peer (
    input logic ckp,
    input logic cke,
    input logic [7:0] tx_byte,
    input logic frame_go,
    input logic [1:0] fault,
    input logic sck_out,
    input logic sck_oe,
    input logic sdo_out,
    input logic scl_oe,
    input logic sda_oe,
    output logic sck_line,
    output logic sdi_line,
    output logic ss_n,
    output logic scl_line,
    output logic sda_line,
    output logic [7:0] rx_byte
);
    logic tgl = 1'b0;
    logic scl_pull = 1'b0;
    logic [8:0] tx_q = 9'h000;
    initial ss_n = 1'b1;
    initial rx_byte = 8'h00;
    ////////////////////////////////////////////////////////////
    // pulled-up lines read low while either side pulls
    assign scl_line = !(scl_oe || scl_pull);
    assign sda_line = !(sda_oe || fault == 2'h1);
    assign sck_line = sck_oe ? sck_out : (ckp ^ tgl);
    // deselected line shows the inverse so a stale bit never matches
    assign sdi_line = (ss_n && !sck_oe) ? !tx_q[8] : tx_q[8];
    always @(sck_line) begin
        if (sck_line == (ckp ^ cke)) begin
            rx_byte = {rx_byte[6:0], sdo_out};
        end else begin
            tx_q = {tx_q[7:0], 1'b0};
        end
    end
    always @(posedge frame_go) begin
        tx_q = cke ? {tx_byte, 1'b0} : {!tx_byte[7], tx_byte};
        rx_byte = 8'h00;
        if (!sck_oe) begin
            // off the clock edge so the pin filter never races the peer
            #408 ss_n = 1'b0;
            #200;
            repeat (16) begin
                tgl = !tgl;
                #40;
            end
            #60 ss_n = 1'b1;
        end
    end
    always @(posedge scl_line) begin
        if (fault == 2'h2) begin
            #52 scl_pull = 1'b1;
            #200 scl_pull = 1'b0;
        end
    end
endmodule : ssr_peer

/* File: sim/tb_top.sv */
// Purpose: self-checking bench for the serial port block
// Assumes: ssr_peer on the pins; tmr2_match pulses every 10 clk
// Notes: /4 receive data unchecked, pin filtering eats its margin
`timescale 1ns/100ps
module tb_top;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic [7:0] ctl = 8'h00, sts = 8'h00, baud = 8'h00, wdat = 8'h00, ptx = 8'h00;
    logic wr = 1'b0, tm = 1'b0, req = 1'b0, clr = 1'b0, go = 1'b0;
    logic [1:0] flt = 2'h0;
    logic [7:0] rbuf, prx;
    logic done, busy, sdo, sdo_oe, sck, sck_oe, rbusy, rdone, coll, scl_oe, sda_oe;
    logic sck_l, sdi_l, ss_l, scl_l, sda_l;
    logic [31:0] seed = 32'h00013051;
    int bad_count = 0;
    int checks_done = 0;
    int cyc = 0;
    int n;
    ssr_top DUT (.clk(clk), .reset_n(reset_n), .serial_port_control_one(ctl),
        .serial_port_status_reg(sts), .addr_or_baud_reload_reg(baud), .buf_wr_en(wr),
        .buf_wr_data(wdat), .tmr2_match(tm), .serial_transfer_buffer(rbuf),
        .spi_done(done), .spi_busy(busy), .sdi_in(sdi_l), .sdo_out(sdo), .sdo_oe(sdo_oe),
        .sck_in(sck_l), .sck_out(sck), .sck_oe(sck_oe), .ss_n_in(ss_l), .rstart_req(req),
        .rstart_busy(rbusy), .rstart_done(rdone), .bus_coll(coll), .bus_coll_clr(clr),
        .scl_in(scl_l), .scl_out(), .scl_oe(scl_oe), .sda_in(sda_l), .sda_out(),
        .sda_oe(sda_oe));
    ssr_peer u_peer (.ckp(ctl[4]), .cke(sts[6]), .tx_byte(ptx), .frame_go(go),
        .fault(flt), .sck_out(sck), .sck_oe(sck_oe), .sdo_out(sdo), .scl_oe(scl_oe),
        .sda_oe(sda_oe), .sck_line(sck_l), .sdi_line(sdi_l), .ss_n(ss_l),
        .scl_line(scl_l), .sda_line(sda_l), .rx_byte(prx));
    ////////////////////////////////////////////////////////////
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd
    task automatic complete_run();
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : complete_run
    task automatic chk_v(input string nm, input logic [7:0] e, input logic [7:0] g);
        checks_done++;
        if (g !== e) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask : chk_v
    task automatic chk_n(input string nm, input int lo, input int hi, input int g);
        checks_done++;
        if (g < lo || g > hi) begin
            bad_count++;
            $display("wrong value %s expected %0d..%0d seen %0d", nm, lo, hi, g);
        end
    endtask : chk_n
    task automatic spi_xfer(input int i);
        logic [31:0] r;
        logic [3:0] m;
        logic [2:0] o;
        int h;
        int e;
        r = rnd();
        m = 4'(i % 6);
        o = {r[2] & (m < 4'h4), 2'(i % 4)};
        h = (m == 4'h0) ? 2 : (m == 4'h1) ? 8 : (m == 4'h2) ? 32 : 10;
        e = 16 * h + 1 + ((o[2] && !o[1]) ? h : 0);
        @(posedge clk);
        // options change while off, so a new polarity never looks like a slave clock edge
        ctl <= {3'h0, o[0], m};
        sts <= {o[2], o[1], 6'h00};
        wdat <= r[15:8];
        ptx <= r[23:16];
        repeat (6) @(posedge clk);
        ctl[ssr_pkg::CTL_EN_BIT] <= 1'b1;
        repeat (6) @(posedge clk);
        #1;
        chk_v("sck idle", {7'h00, o[0]}, {7'h00, sck_l});
        chk_v("sck drive", {7'h00, m < 4'h4}, {7'h00, sck_oe});
        @(posedge clk);
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        wr <= 1'b1;
        @(posedge clk);
        // a running master drops the second write; an idle slave still takes it
        wdat <= ~r[15:8];
        @(posedge clk);
        wr <= 1'b0;
        #1;
        chk_v("busy", {7'h00, m < 4'h4}, {7'h00, busy});
        chk_v("sdo drive", {7'h00, m != 4'h4}, {7'h00, sdo_oe});
        n = 2;
        while (done !== 1'b1 && n < 3000) begin
            @(posedge clk);
            #1;
            n++;
        end
        if (m < 4'h3) chk_n("byte time", e, e, n);
        if (m < 4'h4) chk_v("peer got", r[15:8], prx);
        else chk_v("slave sent", ~r[15:8], prx);
        if (m != 4'h0) chk_v("buffer", r[23:16], rbuf);
    endtask : spi_xfer
    task automatic rs_run(input logic [1:0] f);
        logic [31:0] x;
        int r;
        int t_rel;
        int t_sda;
        int t_end;
        x = rnd();
        r = 6 + int'(x[2:0]);
        t_rel = 0;
        t_sda = 0;
        t_end = 0;
        @(posedge clk);
        ctl <= 8'h28;
        baud <= {x[7], 7'(r)};
        flt <= f;
        repeat (40) @(posedge clk);
        req <= 1'b1;
        @(posedge clk);
        req <= 1'b0;
        for (n = 1; n < 500 && t_end == 0; n++) begin
            @(posedge clk);
            #1;
            if (!scl_oe && t_rel == 0) t_rel = n;
            if (sda_oe && t_sda == 0) t_sda = n;
            if (rdone || coll) t_end = n;
        end
        chk_n("release time", r + 3, r + 3, t_rel);
        if (f == 2'h0) begin
            chk_n("data drive time", t_rel + r + 4, t_rel + r + 8, t_sda);
            chk_n("clock drive time", t_sda + r + 2, t_sda + r + 4, t_end);
            chk_v("lines held", 8'h06, {5'h00, scl_oe, sda_oe, rbusy});
            chk_v("no coll", 8'h00, {7'h00, coll});
        end else begin
            if (f == 2'h1) chk_n("coll time", t_rel + 3, t_rel + 7, t_end);
            chk_v("coll flag", 8'h01, {7'h00, coll});
            chk_v("lines freed", 8'h00, {5'h00, scl_oe, sda_oe, rbusy});
            chk_n("no data drive", 0, 0, t_sda);
        end
        @(posedge clk);
        flt <= 2'h0;
        clr <= 1'b1;
        @(posedge clk);
        clr <= 1'b0;
        @(posedge clk);
        #1;
        chk_v("coll cleared", 8'h00, {7'h00, coll});
    endtask : rs_run
    ////////////////////////////////////////////////////////////
    initial begin
        forever #5 clk = !clk;
    end
    always @(posedge clk) begin
        cyc <= cyc + 1;
        tm <= (cyc % 10 == 9);
        if (cyc == 40000) begin
            bad_count++;
            complete_run();
        end
    end
    initial begin
        repeat (16) @(posedge clk);
        reset_n <= 1'b1;
        repeat (10) @(posedge clk);
        #1;
        chk_v("reset buffer", 8'h00, rbuf);
        for (int i = 0; i < 12; i++) begin
            spi_xfer(i);
        end
        rs_run(2'h0);
        rs_run(2'h2);
        rs_run(2'h1);
        rs_run(2'h0);
        complete_run();
    end
endmodule : tb_top
